// ===== design/asca_pkg.sv
// Package: register map, field positions and encodings of serial control register A
package asca_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] ASCA_IDX_CTRL_A_CH0 = 8'h00;
  localparam logic [7:0] ASCA_IDX_CTRL_A_CH1 = 8'h01;
  localparam logic [7:0] ASCA_IDX_IRQ_STAT = 8'h02;
  localparam logic [7:0] ASCA_IDX_IRQ_MASK = 8'h03;
  localparam logic [7:0] ASCA_IDX_FMT_CTRL = 8'h04;
  localparam logic [7:0] ASCA_IDX_FLAGS = 8'h05;
  localparam int ASCA_ADDR_SHIFT = 2;

  // Control register A fields
  localparam int ASCA_B_WAKE = 7;
  localparam int ASCA_B_RXON = 6;
  localparam int ASCA_B_TXON = 5;
  localparam int ASCA_B_CH = 4;
  localparam int ASCA_B_ADDR = 3;
  localparam int ASCA_B_WIDTH = 2;
  localparam int ASCA_B_PAR = 1;
  localparam int ASCA_B_STOP = 0;

  localparam logic [7:0] ASCA_RST_CTRL_CH0 = 8'h10;
  localparam logic [7:0] ASCA_RST_CTRL_CH1 = 8'h00;
  localparam logic [7:0] ASCA_WRITE_MASK = 8'hf7;

  // Per-channel flag positions (flags register and interrupt status)
  localparam int ASCA_F_FULL = 0;
  localparam int ASCA_F_OVERRUN_FLAG = 1;
  localparam int ASCA_F_FRAME = 2;
  localparam int ASCA_F_PAR = 3;
  localparam int ASCA_F_TXE = 4;
  localparam int ASCA_NFLAGS = 5;
  localparam int ASCA_CH_STRIDE = 8;
endpackage

// ===== design/asca_ctrl.sv
// Two-channel async serial control register A with flags, format decode and interrupt
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Without address frame format, wake filter bit has no effect.
// - Address format with filter on: only address-bit-one bytes set flags.
// - Address format with filter off: every byte updates flags.
// - Receiver enable gates reception; clearing aborts frame, flags kept.
// - Receiver enable forced to zero in reset and io halt.
// - Transmitter enable gates sending; clearing aborts, empty flag held.
// - Transmitter enable forced to zero in reset and io halt.
// - Channel 0 bit 4 drives active-low request-to-send output directly.
// - Bit 3 read returns last received address bit in address format.
// - Writing zero to bit 3 clears overrun, framing, parity flags.
// - Address bit read-back is not initialised by reset.
// - Bits 2-0 choose data width, parity and stop count.
// - Channel 1 bit 4 selects end-of-transfer output or serial clock.
// - Address format frame carries address bit instead of parity.
module asca_ctrl
  import asca_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Chip state
  input wire logic io_halt_state_i,
  // Receiver and transmitter events per channel (same clock)
  input wire logic [NCH-1:0] rx_done_i,
  input wire logic [NCH-1:0] rx_addr_bit_i,
  input wire logic [NCH-1:0] rx_overrun_i,
  input wire logic [NCH-1:0] rx_frame_err_i,
  input wire logic [NCH-1:0] rx_parity_err_i,
  input wire logic [NCH-1:0] rx_data_read_i,
  input wire logic [NCH-1:0] tx_load_i,
  input wire logic [NCH-1:0] tx_taken_i,
  // Controls to the shifters
  output logic [NCH-1:0] rx_on_o,
  output logic [NCH-1:0] tx_on_o,
  output logic [NCH-1:0] data_width_sel_o,
  output logic [NCH-1:0] parity_on_o,
  output logic [NCH-1:0] stop_count_sel_o,
  output logic [NCH-1:0] address_frame_format_o,
  // Pins
  output logic request_to_send_ch0_n_o,
  output logic ch1_clock_pin_select_o,
  // Interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[7:ASCA_ADDR_SHIFT] == idx[7-ASCA_ADDR_SHIFT:0]);
  endfunction

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel_i && penable_i && pwrite_i && clk_en_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i && clk_en_i;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff [NCH];
  logic [7:0] nxt_ctrl [NCH];
  logic [NCH-1:0] addr_rb_ff;
  logic [NCH-1:0] nxt_addr_rb;
  logic [NCH-1:0] fmt_ff;
  logic [NCH-1:0] nxt_fmt;
  logic [ASCA_NFLAGS-1:0] flag_ff [NCH];
  logic [ASCA_NFLAGS-1:0] nxt_flag [NCH];
  logic [ASCA_NFLAGS-1:0] ist_ff [NCH];
  logic [ASCA_NFLAGS-1:0] nxt_ist [NCH];
  logic [ASCA_NFLAGS-1:0] imask_ff [NCH];
  logic [ASCA_NFLAGS-1:0] nxt_imask [NCH];
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic irq_ff;
  logic nxt_irq;
  logic rts_n_ff;
  logic nxt_rts_n;
  logic clk_sel_ff;
  logic nxt_clk_sel;
  // Pin-side parity enable gets its own flop; address format overrides it
  logic [NCH-1:0] par_on_ff;
  logic [NCH-1:0] nxt_par_on;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic mapped;
    logic accept;
    logic [ASCA_NFLAGS-1:0] ev;
    logic [ASCA_NFLAGS-1:0] irq_any;
    logic [7:0] ctl_idx;
    mapped = 1'b0;
    accept = 1'b0;
    ev = '0;
    irq_any = '0;
    ctl_idx = 8'h00;
    nxt_addr_rb = addr_rb_ff;
    nxt_fmt = fmt_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    // One wait state: answer comes on the second access cycle
    nxt_pready = psel_i && penable_i && !pready_ff;
    for (int c = 0; c < NCH; c++) begin
      nxt_ctrl[c] = ctrl_ff[c];
      nxt_flag[c] = flag_ff[c];
      nxt_ist[c] = ist_ff[c];
      nxt_imask[c] = imask_ff[c];
      ctl_idx = (c == 0) ? ASCA_IDX_CTRL_A_CH0 : ASCA_IDX_CTRL_A_CH1;
      // Control register write; read-back bit is not stored
      if (wr_acc && pready_ff && hit(paddr_i, ctl_idx)) begin
        nxt_ctrl[c] = (pwdata_i[7:0] & ASCA_WRITE_MASK) | (ctrl_ff[c] & ~ASCA_WRITE_MASK);
        if (!pwdata_i[ASCA_B_ADDR]) begin
          nxt_flag[c][ASCA_F_OVERRUN_FLAG] = 1'b0;
          nxt_flag[c][ASCA_F_FRAME] = 1'b0;
          nxt_flag[c][ASCA_F_PAR] = 1'b0;
        end
      end
      if (wr_acc && pready_ff && hit(paddr_i, ASCA_IDX_FMT_CTRL)) begin
        nxt_fmt[c] = pwdata_i[c];
      end
      if (wr_acc && pready_ff && hit(paddr_i, ASCA_IDX_IRQ_MASK)) begin
        nxt_imask[c] = pwdata_i[c*ASCA_CH_STRIDE +: ASCA_NFLAGS];
      end
      if (wr_acc && pready_ff && hit(paddr_i, ASCA_IDX_IRQ_STAT)) begin
        nxt_ist[c] = ist_ff[c] & ~pwdata_i[c*ASCA_CH_STRIDE +: ASCA_NFLAGS];
      end
      // Reading data clears full flag; a new byte after it wins below
      if (rx_data_read_i[c]) begin
        nxt_flag[c][ASCA_F_FULL] = 1'b0;
      end
      if (tx_load_i[c] && ctrl_ff[c][ASCA_B_TXON]) begin
        nxt_flag[c][ASCA_F_TXE] = 1'b0;
      end
      if (tx_taken_i[c] && ctrl_ff[c][ASCA_B_TXON]) begin
        nxt_flag[c][ASCA_F_TXE] = 1'b1;
      end
      // Receive acceptance: wake filter, then enabled receiver
      if (!fmt_ff[c] || !ctrl_ff[c][ASCA_B_WAKE]) begin
        accept = rx_done_i[c];
      end else begin
        accept = rx_done_i[c] && rx_addr_bit_i[c];
      end
      accept = accept && ctrl_ff[c][ASCA_B_RXON];
      ev = '0;
      if (accept) begin
        ev[ASCA_F_FULL] = 1'b1;
        ev[ASCA_F_OVERRUN_FLAG] = rx_overrun_i[c];
        ev[ASCA_F_FRAME] = rx_frame_err_i[c];
        // Address format carries no parity bit
        ev[ASCA_F_PAR] = rx_parity_err_i[c] && ctrl_ff[c][ASCA_B_PAR] && !fmt_ff[c];
      end
      if (rx_done_i[c] && ctrl_ff[c][ASCA_B_RXON]) begin
        nxt_addr_rb[c] = rx_addr_bit_i[c];
      end
      // Sets win over clears
      nxt_flag[c] = nxt_flag[c] | ev;
      nxt_ist[c] = nxt_ist[c] | ev;
      if (tx_taken_i[c] && ctrl_ff[c][ASCA_B_TXON]) begin
        nxt_ist[c][ASCA_F_TXE] = 1'b1;
      end
      // Halt clears flags as reset does; tx empty reads as set
      if (io_halt_state_i) begin
        nxt_ctrl[c][ASCA_B_RXON] = 1'b0;
        nxt_ctrl[c][ASCA_B_TXON] = 1'b0;
        nxt_flag[c] = '0;
        nxt_flag[c][ASCA_F_TXE] = 1'b1;
      end
      nxt_par_on[c] = nxt_ctrl[c][ASCA_B_PAR] && !nxt_fmt[c];
      // From next state, so irq tracks the status without a cycle of lag
      irq_any = irq_any | (nxt_ist[c] & nxt_imask[c]);
      // Read data
      // Latched in the first access cycle only, so it stands while pready does
      if (rd_acc && !pready_ff && hit(paddr_i, ctl_idx)) begin
        nxt_prdata = {24'h000000, ctrl_ff[c]};
        nxt_prdata[ASCA_B_ADDR] = fmt_ff[c] ? addr_rb_ff[c] : 1'b0;
      end
      mapped = mapped | hit(paddr_i, ctl_idx);
    end
    mapped = mapped | hit(paddr_i, ASCA_IDX_IRQ_STAT) | hit(paddr_i, ASCA_IDX_IRQ_MASK)
           | hit(paddr_i, ASCA_IDX_FMT_CTRL) | hit(paddr_i, ASCA_IDX_FLAGS);
    if (rd_acc && !pready_ff) begin
      if (hit(paddr_i, ASCA_IDX_IRQ_STAT) || hit(paddr_i, ASCA_IDX_IRQ_MASK)
          || hit(paddr_i, ASCA_IDX_FLAGS) || hit(paddr_i, ASCA_IDX_FMT_CTRL)) begin
        nxt_prdata = 32'h00000000;
      end
      for (int c = 0; c < NCH; c++) begin
        if (hit(paddr_i, ASCA_IDX_IRQ_STAT)) begin
          nxt_prdata[c*ASCA_CH_STRIDE +: ASCA_NFLAGS] = ist_ff[c];
        end
        if (hit(paddr_i, ASCA_IDX_IRQ_MASK)) begin
          nxt_prdata[c*ASCA_CH_STRIDE +: ASCA_NFLAGS] = imask_ff[c];
        end
        if (hit(paddr_i, ASCA_IDX_FLAGS)) begin
          nxt_prdata[c*ASCA_CH_STRIDE +: ASCA_NFLAGS] = flag_ff[c];
        end
        if (hit(paddr_i, ASCA_IDX_FMT_CTRL)) begin
          nxt_prdata[c] = fmt_ff[c];
        end
      end
      if (!mapped) begin
        nxt_prdata = 32'h00000000;
      end
    end
    // Unmapped or unaligned: error rides with the answer, write dropped
    if (psel_i && penable_i && !pready_ff && !mapped) begin
      nxt_pslverr = 1'b1;
    end
    nxt_irq = |irq_any;
    // Pin follows the written value at the write edge, no extra delay
    nxt_rts_n = nxt_ctrl[0][ASCA_B_CH];
    // Single-channel builds hold the pin select low
    nxt_clk_sel = (NCH > 1) ? nxt_ctrl[NCH-1][ASCA_B_CH] : 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_ff[c] <= (c == 0) ? ASCA_RST_CTRL_CH0 : ASCA_RST_CTRL_CH1;
        flag_ff[c] <= '0;
        flag_ff[c][ASCA_F_TXE] <= 1'b1;
        ist_ff[c] <= '0;
        imask_ff[c] <= '0;
      end
      fmt_ff <= '0;
      par_on_ff <= '0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
      rts_n_ff <= ASCA_RST_CTRL_CH0[ASCA_B_CH];
      clk_sel_ff <= 1'b0;
    end else if (clk_en_i) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_ff[c] <= nxt_ctrl[c];
        flag_ff[c] <= nxt_flag[c];
        ist_ff[c] <= nxt_ist[c];
        imask_ff[c] <= nxt_imask[c];
      end
      fmt_ff <= nxt_fmt;
      par_on_ff <= nxt_par_on;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
      rts_n_ff <= nxt_rts_n;
      clk_sel_ff <= nxt_clk_sel;
    end
  end

  // Left out of reset on purpose; value after reset undefined
  always_ff @(posedge mclk_i) begin
    if (clk_en_i) begin
      addr_rb_ff <= nxt_addr_rb;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_out
      assign rx_on_o[g] = ctrl_ff[g][ASCA_B_RXON];
      assign tx_on_o[g] = ctrl_ff[g][ASCA_B_TXON];
      assign data_width_sel_o[g] = ctrl_ff[g][ASCA_B_WIDTH];
      assign parity_on_o[g] = par_on_ff[g];
      assign stop_count_sel_o[g] = ctrl_ff[g][ASCA_B_STOP];
      assign address_frame_format_o[g] = fmt_ff[g];
    end
  endgenerate

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o = irq_ff;
  assign request_to_send_ch0_n_o = rts_n_ff;
  assign ch1_clock_pin_select_o = clk_sel_ff;
endmodule
`default_nettype wire

// ===== testbench/asca_ctrl_assertions.sv
// Checker: port-level properties of serial control register A
`timescale 1ns/1ps
`default_nettype none
module asca_ctrl_assertions
  import asca_pkg::*;
#(parameter int NCH = 2) (
  // Clock, reset, bus
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Controls and pins
  input wire logic io_halt_state_i,
  input wire logic [NCH-1:0] rx_on_o,
  input wire logic [NCH-1:0] tx_on_o,
  input wire logic [NCH-1:0] data_width_sel_o,
  input wire logic [NCH-1:0] parity_on_o,
  input wire logic [NCH-1:0] stop_count_sel_o,
  input wire logic [NCH-1:0] address_frame_format_o,
  input wire logic request_to_send_ch0_n_o,
  input wire logic ch1_clock_pin_select_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  wire logic wr_ok = psel_i && penable_i && pready_o && pwrite_i && !io_halt_state_i;
  rts_ch0_a: assert property (disable iff (!rst_n_i) wr_ok && paddr_i == 8'h00 |-> ##2
    {rx_on_o[0], tx_on_o[0], request_to_send_ch0_n_o, data_width_sel_o[0], stop_count_sel_o[0]}
    == $past({pwdata_i[6:4], pwdata_i[2], pwdata_i[0]}, 2)) else $error("ch0 controls wrong");
  sel_ch1_a: assert property (disable iff (!rst_n_i) wr_ok && paddr_i == 8'h04 |-> ##2
    {rx_on_o[1], tx_on_o[1], ch1_clock_pin_select_o, data_width_sel_o[1], stop_count_sel_o[1]}
    == $past({pwdata_i[6:4], pwdata_i[2], pwdata_i[0]}, 2)) else $error("ch1 controls wrong");
  halt_off_a: assert property (disable iff (!rst_n_i) io_halt_state_i [*2] |->
    rx_on_o == '0 && tx_on_o == '0) else $error("enables not cleared in halt");
  rst_val_a: assert property (!rst_n_i [*2] |-> rx_on_o == '0 && tx_on_o == '0 &&
    request_to_send_ch0_n_o && !irq_o && !pready_o) else $error("reset values wrong");
  addr_nopar_a: assert property (disable iff (!rst_n_i) (parity_on_o & address_frame_format_o) == '0)
    else $error("parity on in address format");
  par_wr_a: assert property (disable iff (!rst_n_i) wr_ok && paddr_i == 8'h00 |=>
    parity_on_o[0] == ($past(pwdata_i[1]) && !address_frame_format_o[0])) else $error("ch0 parity enable wrong");
  rdy_lat_a: assert property (disable iff (!rst_n_i) psel_i && !penable_i |-> ##2 pready_o)
    else $error("pready late");
  rdy_pulse_a: assert property (disable iff (!rst_n_i) pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_map_a: assert property (disable iff (!rst_n_i) pready_o |->
    pslverr_o == (paddr_i > 8'h14 || paddr_i[1:0] != 2'b00)) else $error("slave error wrong");
endmodule
bind asca_ctrl asca_ctrl_assertions #(.NCH(NCH)) chk_u (.mclk_i, .rst_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .io_halt_state_i, .rx_on_o, .tx_on_o,
  .data_width_sel_o, .parity_on_o, .stop_count_sel_o, .address_frame_format_o,
  .request_to_send_ch0_n_o, .ch1_clock_pin_select_o, .irq_o);
`default_nettype wire

// ===== testbench/asca_station.sv
// Remote station model: delivers received frames to the receiver event inputs
`timescale 1ns/1ps
`default_nettype none
module asca_station (
  input wire logic mclk_i,
  input wire logic [1:0] fmt_i,
  input wire logic [1:0] wid_i,
  input wire logic [1:0] par_i,
  input wire logic [1:0] stp_i,
  output logic [1:0] done_o,
  output logic [1:0] mpb_o,
  output logic [1:0] fe_o,
  output logic [1:0] pe_o,
  output logic [1:0] ov_o
);
  initial {done_o, mpb_o, fe_o, pe_o, ov_o} = '0;
  // Frame time from the format; qualifiers invert once no longer valid
  task automatic send(input int c, input logic m, input logic f, input logic p, input logic o = 1'b0);
    repeat (9 + wid_i[c] + (fmt_i[c] | par_i[c]) + stp_i[c]) @(posedge mclk_i);
    done_o[c] <= 1'b1;
    mpb_o[c] <= m;
    fe_o[c] <= f;
    pe_o[c] <= p & ~fmt_i[c];
    ov_o[c] <= o;
    @(posedge mclk_i);
    done_o[c] <= 1'b0;
    {mpb_o[c], fe_o[c], pe_o[c], ov_o[c]} <= ~{m, f, p, o};
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Testbench: register, receive filter, transmit, interrupt and halt checks
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, rst_n_i = 0, clk_en = 1, psel = 0, pen = 0, pwr = 0, halt = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic prdy, perr, serr, rts_n, csel, irq;
  logic [1:0] rdr = 0, tld = 0, ttk = 0, done, frame_address_bit, fe, pe, ron, ton, wid, par, stp, fmt, ovr;
  int err_count = 0, checks_done = 0;
  asca_ctrl dut_u (.mclk_i, .rst_n_i, .clk_en_i(clk_en), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .io_halt_state_i(halt),
    .rx_done_i(done), .rx_addr_bit_i(frame_address_bit), .rx_overrun_i(ovr), .rx_frame_err_i(fe), .rx_parity_err_i(pe),
    .rx_data_read_i(rdr), .tx_load_i(tld), .tx_taken_i(ttk), .rx_on_o(ron), .tx_on_o(ton),
    .data_width_sel_o(wid), .parity_on_o(par), .stop_count_sel_o(stp), .address_frame_format_o(fmt),
    .request_to_send_ch0_n_o(rts_n), .ch1_clock_pin_select_o(csel), .irq_o(irq));
  asca_station st_u (.mclk_i, .fmt_i(fmt), .wid_i(wid), .par_i(par), .stp_i(stp), .done_o(done),
    .mpb_o(frame_address_bit), .fe_o(fe), .pe_o(pe), .ov_o(ovr));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge mclk_i);
    pen <= 1;
    @(posedge mclk_i);
    while (prdy !== 1'b1) @(posedge mclk_i);
    r = prd;
    serr = perr;
    psel <= 0; pen <= 0;
    @(posedge mclk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(0, a, 0);
    chk(n, e, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  // Pulse {tx_taken, tx_load, data_read} of channel 0
  task automatic ev(input logic [2:0] k);
    {ttk[0], tld[0], rdr[0]} <= k;
    @(posedge mclk_i);
    {ttk, tld, rdr} <= '0;
    @(posedge mclk_i);
  endtask
  task automatic ick(input logic e);
    repeat (2) @(posedge mclk_i);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1;
    rd(8'h00, 32'h10, "ctrl0");
    rd(8'h04, 32'h00, "ctrl1");
    rd(8'h14, 32'h1010, "flags");
    wr(8'h00, 32'h67);
    rd(8'h00, 32'h67, "ctrl0");
    chk("rts_n", 0, {31'h0, rts_n});
    chk("parity", 32'h1, {30'h0, par});
    wr(8'h04, 32'h10);
    chk("clk_sel", 1, {31'h0, csel});
    $display("test registers done");
    wr(8'h00, 32'he7);
    st_u.send(0, 0, 1, 0, 1);
    rd(8'h14, 32'h1017, "flags");
    wr(8'h00, 32'he7);
    rd(8'h14, 32'h1011, "flags");
    ev(3'b001);
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h1, "fmt");
    chk("parity", 0, {30'h0, par});
    st_u.send(0, 0, 1, 1);
    rd(8'h14, 32'h1010, "flags");
    st_u.send(0, 1, 0, 0);
    rd(8'h14, 32'h1011, "flags");
    rd(8'h00, 32'hef, "ctrl0");
    wr(8'h00, 32'h67);
    ev(3'b001);
    st_u.send(0, 0, 1, 0);
    rd(8'h14, 32'h1015, "flags");
    clk_en <= 0;
    ev(3'b001);
    clk_en <= 1;
    rd(8'h14, 32'h1015, "frozen flags");
    $display("test receive done");
    wr(8'h00, 32'h2f);
    st_u.send(0, 1, 0, 0);
    rd(8'h14, 32'h1015, "flags");
    ev(3'b010);
    rd(8'h14, 32'h1005, "flags");
    wr(8'h00, 32'h0f);
    ev(3'b100);
    rd(8'h14, 32'h1005, "flags");
    wr(8'h0c, 32'h1);
    ick(1);
    wr(8'h0c, 32'h0);
    ick(0);
    wr(8'h08, 32'h1f1f);
    wr(8'h0c, 32'h1);
    ick(0);
    $display("test transmit and interrupt done");
    wr(8'h04, 32'h50);
    st_u.send(1, 0, 0, 1);
    rd(8'h14, 32'h1105, "flags");
    wr(8'h00, 32'h6f);
    repeat (3) @(posedge mclk_i);
    halt <= 1;
    repeat (3) @(posedge mclk_i);
    halt <= 0;
    rd(8'h00, 32'h07, "ctrl0");
    rd(8'h14, 32'h1010, "flags");
    rd(8'h18, 32'h0, "unmapped");
    chk("slverr", 1, {31'h0, serr});
    $display("test halt and errors done");
    summarize;
  end
endmodule
`default_nettype wire
